// [hdl/sensor_regs_pkg.sv]
/*
 * Constants, register map, field layout and rate decoding shared by the
 * control/status register bank and its helpers.
 * Assumes a single 250 MHz clock and byte-wide register accesses.
 */
//
// Overview of operation
// [R01] Pulse flag set by enabled event, source read clears
// [R02] Motion flag set by enabled event, source read clears
// [R03] Magnitude flag cleared by summary register read
// [R04] New-sample flag follows mode-selected sensor data
// [R05] New-sample flag cleared by mode-selected data read
// [R06] Hybrid wrap: twelve-byte burst from address one
// [R07] Fixed read-only eight-bit identity value
// [R08] Host changes control fields only in standby
// [R09] Rate field decodes eight rates, reset 400
// [R10] Hybrid mode halves selected output rate
// [R11] Sleep field decodes four auto-wake rates
// [R12] Auto-sleep runs everything from sleep rate
// [R13] Hybrid mode halves sleep rate too
// [R14] Low-noise doubles gain, caps at four g
// [R15] Fast read: high bytes only, skip low; the pointer skips magnetic low bytes only in a hybrid wrap burst
// [R16] Fast read plus wrap: six-byte burst
// [R17] Active bit selects mode, resets to standby
// [R18] Summary read clears only magnitude flag
// [R19] Fast-read bit changes only when fifo off
// [R20] Flags hold until cleared, set beats clear
// [R21] Active-time writes keep other fields unchanged
package sensor_regs_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_ACC_X_HI = 8'h01;
	localparam logic [7:0] ADDR_ACC_Y_HI = 8'h03;
	localparam logic [7:0] ADDR_ACC_Z_HI = 8'h05;
	localparam logic [7:0] ADDR_ACC_Z_LO = 8'h06;
	localparam logic [7:0] ADDR_ACC_END = 8'h07;
	localparam logic [7:0] ADDR_INT_SUMMARY = 8'h0C;
	localparam logic [7:0] ADDR_IDENTITY = 8'h0D;
	localparam logic [7:0] ADDR_FFMT_SRC = 8'h16;
	localparam logic [7:0] ADDR_PULSE_SRC = 8'h22;
	localparam logic [7:0] ADDR_MAIN_CTRL = 8'h2A;
	localparam logic [7:0] ADDR_MAG_X_HI = 8'h33;
	localparam logic [7:0] ADDR_MAG_Y_HI = 8'h35;
	localparam logic [7:0] ADDR_MAG_Z_HI = 8'h37;
	localparam logic [7:0] ADDR_MAG_Z_LO = 8'h38;

	// Arbitrary neutral identity value
	localparam logic [7:0] IDENTITY_VALUE = 8'h5A;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int CTL_ACTIVE = 0;
	localparam int CTL_FREAD = 1;
	localparam int CTL_LNOISE = 2;
	localparam int CTL_RATE_LSB = 3;
	localparam int CTL_SLEEP_LSB = 6;
	localparam logic [7:0] MAIN_CTRL_RESET = 8'h08;
	localparam int INT_PULSE = 3;
	localparam int INT_FFMT = 2;
	localparam int INT_VECM = 1;
	localparam int INT_DRDY = 0;
	localparam int EVENT_ACTIVE_BIT = 7;
	localparam logic [1:0] FIFO_OFF = 2'h0;

	typedef enum logic [1:0] {
		MODE_ACCEL = 2'h0,
		MODE_MAG = 2'h1,
		MODE_HYBRID = 2'h3
	} sensor_mode_t;

	typedef enum logic [2:0] {
		PWR_STANDBY = 3'h1,
		PWR_WAKE = 3'h2,
		PWR_SLEEP = 3'h4
	} power_state_t;

	// ------------------------------------------------------------
	// Timing: all rates are whole multiples of the 800 Hz period
	// ------------------------------------------------------------
	localparam real BASE_PERIOD_MS = 1.25;
	localparam real CLK_PERIOD_NS = 4.0;
	localparam int unsigned BASE_CYCLES = int'(BASE_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);

	// Rate field to period in base units
	function automatic logic [10:0] rate_units(input logic [2:0] sel);
		case (sel)
			3'h0: rate_units = 11'h001;
			3'h1: rate_units = 11'h002;
			3'h2: rate_units = 11'h004;
			3'h3: rate_units = 11'h008;
			3'h4: rate_units = 11'h010;
			3'h5: rate_units = 11'h040;
			3'h6: rate_units = 11'h080;
			default: rate_units = 11'h200;
		endcase
	endfunction

	function automatic logic [10:0] sleep_units(input logic [1:0] sel);
		sleep_units = rate_units({1'b1, sel});
	endfunction

endpackage

// [hdl/sample_rate_timer.sv]
/*
 * Sample timebase: one-cycle tick at the selected output data rate.
 * Assumes period_units_i is stable while enable_i is high.
 */
module sample_rate_timer import sensor_regs_pkg::*; #(
	parameter int unsigned BASE_CYCLES_P = BASE_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic [10:0] period_units_i,
	output logic tick_o
);

	logic [19:0] base_cnt_reg;
	logic [10:0] unit_cnt_reg;
	logic base_tick;

	assign base_tick = (base_cnt_reg == 20'(BASE_CYCLES_P - 1));
	assign tick_o = enable_i && base_tick && (unit_cnt_reg == period_units_i - 11'h001);

	// Restarts from zero on every entry to active so the first sample is a full period late
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			base_cnt_reg <= 20'h00000;
		end else if (!enable_i || base_tick) begin
			base_cnt_reg <= 20'h00000;
		end else begin
			base_cnt_reg <= base_cnt_reg + 20'h00001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unit_cnt_reg <= 11'h000;
		end else if (!enable_i || tick_o) begin
			unit_cnt_reg <= 11'h000;
		end else if (base_tick) begin
			unit_cnt_reg <= unit_cnt_reg + 11'h001;
		end
	end

endmodule

// [hdl/burst_addr_pointer.sv]
/*
 * Register address pointer with burst auto-increment and skips.
 * Assumes the serial front end issues start, read and write strobes.
 */
module burst_addr_pointer import sensor_regs_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [7:0] start_addr_i,
	input wire logic access_i,
	input wire logic fast_read_i,
	input wire logic wrap_i,
	output logic [7:0] cur_addr_o
);

	logic [7:0] ptr_reg;

	function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fr, input logic wr);
		next_addr = a + 8'h01;
		if (fr && a == ADDR_ACC_X_HI) begin
			next_addr = ADDR_ACC_Y_HI; // [R15]
		end else if (fr && a == ADDR_ACC_Y_HI) begin
			next_addr = ADDR_ACC_Z_HI;
		end else if (fr && a == ADDR_ACC_Z_HI) begin
			next_addr = wr ? ADDR_MAG_X_HI : ADDR_ACC_END; // [R16]
		end else if (fr && wr && a == ADDR_MAG_X_HI) begin
			next_addr = ADDR_MAG_Y_HI;
		end else if (fr && wr && a == ADDR_MAG_Y_HI) begin
			next_addr = ADDR_MAG_Z_HI;
		end else if (fr && wr && a == ADDR_MAG_Z_HI) begin
			next_addr = ADDR_ACC_X_HI;
		end else if (wr && a == ADDR_ACC_Z_LO) begin
			next_addr = ADDR_MAG_X_HI; // [R06]
		end else if (wr && a == ADDR_MAG_Z_LO) begin
			next_addr = ADDR_ACC_X_HI;
		end
	endfunction

	assign cur_addr_o = start_i ? start_addr_i : ptr_reg;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_reg <= 8'h00;
		end else if (access_i) begin
			ptr_reg <= next_addr(cur_addr_o, fast_read_i, wrap_i);
		end else if (start_i) begin
			ptr_reg <= start_addr_i;
		end
	end

endmodule

// [hdl/sensor_rate_and_irq_status.sv]
/*
 * Control and status register bank: interrupt summary flags, identity,
 * main control register and the sample timebase it steers.
 * Assumes a serial front end on the same clock that turns host frames
 * into start/read/write strobes, and detection engines on the same clock.
 */
module sensor_rate_and_irq_status import sensor_regs_pkg::*; #(
	parameter int unsigned BASE_CYCLES_P = BASE_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic xfer_start_i,
	input wire logic [7:0] xfer_addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic [1:0] mode_i,
	input wire logic hyb_wrap_i,
	input wire logic [1:0] fifo_mode_i,
	input wire logic auto_sleep_i,
	input wire logic [7:0] pulse_src_i,
	input wire logic pulse_int_en_i,
	input wire logic [7:0] ffmt_src_i,
	input wire logic ffmt_int_en_i,
	input wire logic vecm_int_i,
	input wire logic accel_new_i,
	input wire logic mag_new_i,
	input wire logic [13:0] accel_x_i,
	input wire logic [13:0] accel_y_i,
	input wire logic [13:0] accel_z_i,
	input wire logic [15:0] mag_x_i,
	input wire logic [15:0] mag_y_i,
	input wire logic [15:0] mag_z_i,
	output logic [7:0] int_summary_o,
	output logic active_o,
	output logic lnoise_gain_o,
	output logic fast_read_o,
	output logic [2:0] power_state_o,
	output logic odr_tick_o
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	logic [7:0] cur_addr;
	logic [7:0] main_ctrl_reg;
	logic hybrid;
	logic rd_summary;
	logic rd_pulse;
	logic rd_ffmt;
	logic rd_accel;
	logic rd_mag;
	logic wr_ctrl;

	burst_addr_pointer u_ptr (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.start_i(xfer_start_i),
		.start_addr_i(xfer_addr_i),
		.access_i(rd_i || wr_i),
		.fast_read_i(main_ctrl_reg[CTL_FREAD]),
		.wrap_i(hybrid && hyb_wrap_i),
		.cur_addr_o(cur_addr)
	);

	assign hybrid = (mode_i == MODE_HYBRID);
	assign rd_summary = rd_i && (cur_addr == ADDR_INT_SUMMARY);
	assign rd_pulse = rd_i && (cur_addr == ADDR_PULSE_SRC);
	assign rd_ffmt = rd_i && (cur_addr == ADDR_FFMT_SRC);
	assign rd_accel = rd_i && (cur_addr >= ADDR_ACC_X_HI) && (cur_addr <= ADDR_ACC_Z_LO);
	assign rd_mag = rd_i && (cur_addr >= ADDR_MAG_X_HI) && (cur_addr <= ADDR_MAG_Z_LO);
	assign wr_ctrl = wr_i && (cur_addr == ADDR_MAIN_CTRL);

	// ------------------------------------------------------------
	// Main control register
	// ------------------------------------------------------------
	logic [7:0] main_ctrl_next;

	always_comb begin
		main_ctrl_next = main_ctrl_reg;
		if (!main_ctrl_reg[CTL_ACTIVE]) begin
			main_ctrl_next = wdata_i;
			if (fifo_mode_i != FIFO_OFF) begin
				main_ctrl_next[CTL_FREAD] = main_ctrl_reg[CTL_FREAD]; // [R19]
			end
		end
		// Only the active bit moves while running
		main_ctrl_next[CTL_ACTIVE] = wdata_i[CTL_ACTIVE]; // [R21]
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			main_ctrl_reg <= MAIN_CTRL_RESET; // [R17]
		end else if (wr_ctrl) begin
			main_ctrl_reg <= main_ctrl_next;
		end
	end

	assign active_o = main_ctrl_reg[CTL_ACTIVE];
	assign fast_read_o = main_ctrl_reg[CTL_FREAD];
	// Gain doubled means the front end saturates at four g
	assign lnoise_gain_o = main_ctrl_reg[CTL_LNOISE]; // [R14]

	// ------------------------------------------------------------
	// Power state and sample rate
	// ------------------------------------------------------------
	power_state_t power_state_reg;
	logic [10:0] base_units;
	logic [10:0] period_units;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			power_state_reg <= PWR_STANDBY;
		end else if (!main_ctrl_reg[CTL_ACTIVE]) begin
			power_state_reg <= PWR_STANDBY; // [R17]
		end else if (auto_sleep_i) begin
			power_state_reg <= PWR_SLEEP;
		end else begin
			power_state_reg <= PWR_WAKE;
		end
	end
	assign power_state_o = power_state_reg;

	always_comb begin
		case (power_state_reg)
			PWR_SLEEP: base_units = sleep_units(main_ctrl_reg[CTL_SLEEP_LSB +: 2]); // [R11] [R12]
			default: base_units = rate_units(main_ctrl_reg[CTL_RATE_LSB +: 3]); // [R09]
		endcase
	end

	// Doubling the period halves the rate
	assign period_units = hybrid ? {base_units[9:0], 1'b0} : base_units; // [R10] [R13]

	sample_rate_timer #(
		.BASE_CYCLES_P(BASE_CYCLES_P)
	) u_timer (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.enable_i(power_state_reg != PWR_STANDBY),
		.period_units_i(period_units),
		.tick_o(odr_tick_o)
	);

	// ------------------------------------------------------------
	// Interrupt summary flags
	// ------------------------------------------------------------
	logic pulse_flag_reg;
	logic ffmt_flag_reg;
	logic vecm_flag_reg;
	logic drdy_flag_reg;
	logic pulse_set;
	logic ffmt_set;
	logic drdy_set;
	logic drdy_clr;

	assign pulse_set = pulse_src_i[EVENT_ACTIVE_BIT] && pulse_int_en_i;
	assign ffmt_set = ffmt_src_i[EVENT_ACTIVE_BIT] && ffmt_int_en_i;

	always_comb begin
		case (mode_i)
			MODE_ACCEL: drdy_set = accel_new_i;
			MODE_MAG: drdy_set = mag_new_i;
			MODE_HYBRID: drdy_set = accel_new_i || mag_new_i;
			default: drdy_set = 1'b0;
		endcase
	end
	assign drdy_clr = (mode_i == MODE_ACCEL) ? rd_accel : rd_mag; // [R05]

	// Set is tested first so an event in the clearing cycle survives
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pulse_flag_reg <= 1'b0;
		end else if (pulse_set) begin
			pulse_flag_reg <= 1'b1; // [R01] [R20]
		end else if (rd_pulse) begin
			pulse_flag_reg <= 1'b0; // [R01]
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ffmt_flag_reg <= 1'b0;
		end else if (ffmt_set) begin
			ffmt_flag_reg <= 1'b1; // [R02] [R20]
		end else if (rd_ffmt) begin
			ffmt_flag_reg <= 1'b0; // [R02] [R18]
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			vecm_flag_reg <= 1'b0;
		end else if (vecm_int_i) begin
			vecm_flag_reg <= 1'b1; // [R03] [R20]
		end else if (rd_summary) begin
			vecm_flag_reg <= 1'b0; // [R03]
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			drdy_flag_reg <= 1'b0;
		end else if (drdy_set) begin
			drdy_flag_reg <= 1'b1; // [R04] [R20]
		end else if (drdy_clr) begin
			drdy_flag_reg <= 1'b0;
		end
	end

	always_comb begin
		int_summary_o = 8'h00;
		int_summary_o[INT_PULSE] = pulse_flag_reg;
		int_summary_o[INT_FFMT] = ffmt_flag_reg;
		int_summary_o[INT_VECM] = vecm_flag_reg;
		int_summary_o[INT_DRDY] = drdy_flag_reg;
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;

	// Accel samples are left-justified; the high byte alone serves fast read
	always_comb begin
		rdata_next = 8'h00;
		if (cur_addr == ADDR_ACC_X_HI) begin
			rdata_next = accel_x_i[13:6]; // [R15]
		end else if (cur_addr == ADDR_ACC_X_HI + 8'h01) begin
			rdata_next = {accel_x_i[5:0], 2'h0};
		end else if (cur_addr == ADDR_ACC_Y_HI) begin
			rdata_next = accel_y_i[13:6];
		end else if (cur_addr == ADDR_ACC_Y_HI + 8'h01) begin
			rdata_next = {accel_y_i[5:0], 2'h0};
		end else if (cur_addr == ADDR_ACC_Z_HI) begin
			rdata_next = accel_z_i[13:6];
		end else if (cur_addr == ADDR_ACC_Z_LO) begin
			rdata_next = {accel_z_i[5:0], 2'h0};
		end else if (cur_addr == ADDR_INT_SUMMARY) begin
			rdata_next = int_summary_o;
		end else if (cur_addr == ADDR_IDENTITY) begin
			rdata_next = IDENTITY_VALUE; // [R07]
		end else if (cur_addr == ADDR_FFMT_SRC) begin
			rdata_next = ffmt_src_i;
		end else if (cur_addr == ADDR_PULSE_SRC) begin
			rdata_next = pulse_src_i;
		end else if (cur_addr == ADDR_MAIN_CTRL) begin
			rdata_next = main_ctrl_reg;
		end else if (cur_addr == ADDR_MAG_X_HI) begin
			rdata_next = mag_x_i[15:8];
		end else if (cur_addr == ADDR_MAG_X_HI + 8'h01) begin
			rdata_next = mag_x_i[7:0];
		end else if (cur_addr == ADDR_MAG_Y_HI) begin
			rdata_next = mag_y_i[15:8];
		end else if (cur_addr == ADDR_MAG_Y_HI + 8'h01) begin
			rdata_next = mag_y_i[7:0];
		end else if (cur_addr == ADDR_MAG_Z_HI) begin
			rdata_next = mag_z_i[15:8];
		end else if (cur_addr == ADDR_MAG_Z_LO) begin
			rdata_next = mag_z_i[7:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (rd_i) begin
			rdata_reg <= rdata_next;
		end
	end
	assign rdata_o = rdata_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	sequence s_wrap_last_lo;
		rd_i && cur_addr == ADDR_ACC_Z_LO && hybrid && hyb_wrap_i && !main_ctrl_reg[CTL_FREAD];
	endsequence
	sequence s_wrap_last_hi;
		rd_i && cur_addr == ADDR_ACC_Z_HI && hybrid && hyb_wrap_i && main_ctrl_reg[CTL_FREAD];
	endsequence
	// Pointer is only reloaded by a start strobe, so it is visible on idle cycles
	sequence s_no_restart;
		!xfer_start_i;
	endsequence

	chk_pulse_set: assert property (pulse_set |=> int_summary_o[INT_PULSE]) // [R01]
		else $error("pulse flag not set");
	chk_pulse_clear: assert property (rd_pulse && !pulse_set |=> !int_summary_o[INT_PULSE]) // [R01]
		else $error("pulse flag not cleared by source read");
	chk_ffmt_hold: assert property (ffmt_flag_reg && !rd_ffmt |=> ffmt_flag_reg) // [R02]
		else $error("motion flag dropped without source read");
	chk_vecm_clear: assert property (rd_summary && !vecm_int_i |=> !vecm_flag_reg) // [R03]
		else $error("magnitude flag survived summary read");
	chk_summary_keeps: assert property (rd_summary && drdy_flag_reg |=> drdy_flag_reg) // [R18]
		else $error("summary read cleared a non-magnitude flag");
	chk_drdy_set: assert property (mode_i == MODE_MAG && mag_new_i |=> drdy_flag_reg) // [R04]
		else $error("new-sample flag not raised");
	chk_drdy_clear: assert property (mode_i == MODE_ACCEL && rd_accel && !accel_new_i // [R05]
		|=> !drdy_flag_reg)
		else $error("new-sample flag not cleared by data read");
	chk_set_wins: assert property (vecm_int_i && rd_summary |=> vecm_flag_reg) // [R20]
		else $error("event lost in clearing cycle");
	chk_identity_read: assert property (rd_i && cur_addr == ADDR_IDENTITY // [R07]
		|=> rdata_o == IDENTITY_VALUE)
		else $error("identity value wrong");
	chk_active_lock: assert property (wr_ctrl && main_ctrl_reg[CTL_ACTIVE] // [R21]
		|=> main_ctrl_reg[7:1] == $past(main_ctrl_reg[7:1]))
		else $error("control field changed while active");
	chk_fread_lock: assert property (wr_ctrl && fifo_mode_i != FIFO_OFF // [R19]
		|=> $stable(main_ctrl_reg[CTL_FREAD]))
		else $error("fast-read bit changed with fifo on");
	chk_burst_wrap: assert property (s_wrap_last_lo ##1 s_no_restart // [R06]
		|-> cur_addr == ADDR_MAG_X_HI)
		else $error("hybrid burst did not wrap to magnetic data");
	chk_fast_wrap: assert property (s_wrap_last_hi ##1 s_no_restart // [R16]
		|-> cur_addr == ADDR_MAG_X_HI)
		else $error("fast hybrid burst did not reach magnetic high byte");
	chk_hybrid_rate: assert property (power_state_reg == PWR_WAKE && hybrid // [R10]
		|-> period_units == 11'(rate_units(main_ctrl_reg[CTL_RATE_LSB +: 3]) << 1))
		else $error("hybrid rate not halved");
	chk_sleep_rate: assert property (power_state_reg == PWR_SLEEP && !hybrid // [R12]
		|-> period_units == sleep_units(main_ctrl_reg[CTL_SLEEP_LSB +: 2]))
		else $error("sleep rate not used in auto-sleep");

endmodule

// [dv/host_model.sv]
/*
 * Host model: issues byte reads and writes on the register strobe port.
 * Assumes the bench calls xfer only after reset has been released.
 */
module host_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic start_o,
	output logic [7:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		start_o = 1'b0;
		addr_o = 8'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end

	// ------------------------------------------------------------
	// One transfer: strobes held across exactly one rising edge
	// ------------------------------------------------------------
	task automatic xfer(input logic st, input logic [7:0] a, input logic w,
		input logic [7:0] wd, output logic [7:0] d);
		@(negedge clk_i);
		start_o = st;
		addr_o = a;
		rd_o = !w;
		wr_o = w;
		wdata_o = wd;
		@(negedge clk_i);
		d = rdata_i;
		start_o = 1'b0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		// Released lines flip so stale values never look valid
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask
endmodule

// [dv/test_sensor_rate_and_irq_status.sv]
/*
 * Self-checking bench for the control and status register bank.
 * Assumes a shortened base period of 4 clocks and the host model above.
 */
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %0t: got %h want %h", $time, (g), (e)); end end
module test_sensor_rate_and_irq_status;
	import sensor_regs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [1:0] m;
		logic mag;
		logic set;
		logic [7:0] wa;
		logic [7:0] ra;
	} row_t;

	localparam int BASE = 4;
	logic ref_clk, rst_n, hyb_wrap, auto_sleep, pulse_en, ffmt_en, vecm, acc_new, mag_new;
	logic start, rd, wr, active, lnoise, fread, tick;
	logic [1:0] mode, fifo_mode;
	logic [2:0] pwr;
	logic [7:0] pulse_src, ffmt_src, rdata, isum, addr, wdata, d;
	logic [13:0] acc [3];
	logic [15:0] mag [3];
	logic [7:0] full [12];
	logic [7:0] clr_a [3] = '{8'h22, 8'h16, 8'h0C};
	int units [12] = '{1, 2, 4, 8, 16, 64, 128, 512, 16, 64, 128, 512};
	row_t rows [6] = '{
		'{2'h0, 1'b0, 1'b1, 8'h33, 8'h01}, '{2'h1, 1'b1, 1'b1, 8'h01, 8'h33},
		'{2'h3, 1'b0, 1'b1, 8'h01, 8'h33}, '{2'h3, 1'b1, 1'b1, 8'h05, 8'h38},
		'{2'h1, 1'b0, 1'b0, 8'h01, 8'h33}, '{2'h2, 1'b1, 1'b0, 8'h01, 8'h33}};
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;

	host_model host_model_inst (.clk_i(ref_clk), .rdata_i(rdata), .start_o(start),
		.addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

	sensor_rate_and_irq_status #(.BASE_CYCLES_P(BASE)) sensor_rate_and_irq_status_inst (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n), .xfer_start_i(start), .xfer_addr_i(addr),
		.rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .mode_i(mode),
		.hyb_wrap_i(hyb_wrap), .fifo_mode_i(fifo_mode), .auto_sleep_i(auto_sleep),
		.pulse_src_i(pulse_src), .pulse_int_en_i(pulse_en), .ffmt_src_i(ffmt_src),
		.ffmt_int_en_i(ffmt_en), .vecm_int_i(vecm), .accel_new_i(acc_new),
		.mag_new_i(mag_new), .accel_x_i(acc[0]), .accel_y_i(acc[1]), .accel_z_i(acc[2]),
		.mag_x_i(mag[0]), .mag_y_i(mag[1]), .mag_z_i(mag[2]), .int_summary_o(isum),
		.active_o(active), .lnoise_gain_o(lnoise), .fast_read_o(fread),
		.power_state_o(pwr), .odr_tick_o(tick));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			close_out();
		end
	end

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic rdb(input logic st, input logic [7:0] a);
		host_model_inst.xfer(st, a, 1'b0, 8'h00, d);
	endtask

	task automatic wrb(input logic [7:0] a, input logic [7:0] v);
		host_model_inst.xfer(1'b1, a, 1'b1, v, d);
	endtask

	task automatic raise(input int k, input logic en);
		@(negedge ref_clk);
		if (k == 0) begin
			pulse_src = 8'h80;
			pulse_en = en;
		end else if (k == 1) begin
			ffmt_src = 8'h80;
			ffmt_en = en;
		end else
			vecm = 1'b1;
		@(negedge ref_clk);
		pulse_src = 8'h00;
		ffmt_src = 8'h00;
		vecm = 1'b0;
	endtask

	task automatic new_data(input logic m);
		@(negedge ref_clk);
		acc_new = !m;
		mag_new = m;
		@(negedge ref_clk);
		acc_new = 1'b0;
		mag_new = 1'b0;
	endtask

	// Bounded wait for one tick, then cycles to the next
	task automatic period(output int p);
		int w;
		w = 0;
		while (tick !== 1'b1 && w < 5000) begin
			@(negedge ref_clk);
			w++;
		end
		p = 0;
		do begin
			@(negedge ref_clk);
			p++;
		end while (tick !== 1'b1 && p < 5000);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, hyb_wrap, auto_sleep, pulse_en, ffmt_en, vecm, acc_new, mag_new} = 8'h00;
		{mode, fifo_mode, pulse_src, ffmt_src} = 20'h00000;
		acc = '{14'h2A5C, 14'h1357, 14'h3FC1};
		mag = '{16'hA1B2, 16'h0C3D, 16'h7E4F};
		for (int a = 0; a < 3; a++) begin
			full[2 * a] = acc[a][13:6];
			full[2 * a + 1] = {acc[a][5:0], 2'b00};
			full[6 + 2 * a] = mag[a][15:8];
			full[7 + 2 * a] = mag[a][7:0];
		end
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		`CHK(pwr, 3'h1)
		`CHK(isum, 8'h00)
		rdb(1'b1, 8'h0D);
		`CHK(d, 8'h5A)
		wrb(8'h0D, 8'h00);
		rdb(1'b1, 8'h0D);
		`CHK(d, 8'h5A)
		rdb(1'b1, 8'h2A);
		`CHK(d, 8'h08)
		rdb(1'b1, 8'h50);
		`CHK(d, 8'h00)
		wrb(8'h2A, 8'h09);
		`CHK(active, 1'b1)
		// Host writes fields while active on purpose here
		wrb(8'h2A, 8'hF7);
		rdb(1'b1, 8'h2A);
		`CHK(d, 8'h09)
		wrb(8'h2A, 8'h00);
		rdb(1'b1, 8'h2A);
		`CHK(d, 8'h08)
		fifo_mode = 2'h1;
		wrb(8'h2A, 8'h06);
		rdb(1'b1, 8'h2A);
		`CHK(d, 8'h04)
		fifo_mode = 2'h0;
		wrb(8'h2A, 8'h06);
		`CHK(fread, 1'b1)
		`CHK(lnoise, 1'b1)
		for (int r = 0; r < 6; r++) begin
			mode = rows[r].m;
			new_data(rows[r].mag);
			`CHK(isum[0], rows[r].set)
			rdb(1'b1, rows[r].wa);
			`CHK(isum[0], rows[r].set)
			rdb(1'b1, rows[r].ra);
			`CHK(isum[0], 1'b0)
		end
		for (int i = 0; i < 3; i++) begin
			if (i < 2) begin
				raise(i, 1'b0);
				`CHK(isum[3 - i], 1'b0)
			end
			raise(i, 1'b1);
			`CHK(isum[3 - i], 1'b1)
			rdb(1'b1, i == 2 ? 8'h22 : 8'h0C);
			`CHK(isum[3 - i], 1'b1)
			rdb(1'b1, clr_a[i]);
			`CHK(isum[3 - i], 1'b0)
		end
		@(negedge ref_clk);
		pulse_src = 8'h80;
		rdb(1'b1, 8'h22);
		`CHK(isum[3], 1'b1)
		pulse_src = 8'h00;
		rdb(1'b1, 8'h22);
		`CHK(isum[3], 1'b0)
		vecm = 1'b1;
		rdb(1'b1, 8'h0C);
		`CHK(isum[1], 1'b1)
		vecm = 1'b0;
		rdb(1'b1, 8'h0C);
		`CHK(isum[1], 1'b0)
		hyb_wrap = 1'b1;
		for (int c = 0; c < 3; c++) begin
			mode = c == 1 ? 2'h0 : 2'h3;
			wrb(8'h2A, c == 0 ? 8'h08 : 8'h0A);
			for (int j = 0; j < (c == 0 ? 13 : c == 1 ? 3 : 7); j++) begin
				rdb(j == 0, 8'h01);
				`CHK(d, full[c == 0 ? j % 12 : (2 * j) % 12])
			end
		end
		// Rate changes made from standby only
		for (int h = 0; h < 2; h++) begin
			for (int k = 0; k < 12; k++) begin
				mode = h ? 2'h3 : 2'h0;
				auto_sleep = k >= 8;
				wrb(8'h2A, k >= 8 ? 8'(((k - 8) << 6) | 1) : 8'((k << 3) | 1));
				period(n);
				`CHK(n, units[k] * BASE * (h + 1))
				`CHK(pwr, k >= 8 ? 3'h4 : 3'h2)
				wrb(8'h2A, 8'h00);
			end
		end
		rst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		rdb(1'b1, 8'h2A);
		`CHK(d, 8'h08)
		close_out();
	end
endmodule
